// [common/lpm_params.svh]
// Constants for the low-power mode controller: register offsets, field positions,
// reset values and timing counts. Assumes a 25 MHz system clock.
`ifndef LPM_PARAMS_SVH
`define LPM_PARAMS_SVH
`define CTRL_OFFSET 12'h000
`define STATUS_OFFSET 12'h004
`define CCW_OFFSET 12'h008
`define OPCODE_OFFSET 12'h00C
`define STACK_OFFSET 12'h010
`define CTRL_WAIT_SEL_BIT 0
`define CTRL_WDOG_OFF_BIT 1
`define CTRL_CONV_ON_BIT 2
`define CTRL_SYNC_ON_BIT 3
`define CTRL_SEND_ON_BIT 4
`define CTRL_LISTEN_ON_BIT 5
`define CTRL_RESET 6'h01
`define CCW_STOP_DIS_BIT 7
`define CCW_NMI_MASK_BIT 6
`define CCW_INT_MASK_BIT 4
`define CCW_RESET 8'hD0
`define CMD_IDLE 2'h1
`define CMD_STOP 2'h2
`define OSC_WAIT_CYCLES 16'h0FA0
`define STACK_TOP 16'h00FF
`define CCW_STACK_DEPTH 16'h0008
`endif

// [common/lpm_pkg.sv]
// Types shared by the low-power mode controller files.
package lpm_pkg;
  typedef enum logic [2:0] {
    RUN, STACKING, IDLE, STOPPED, OSC_WAIT, VECTOR
  } lpm_state_t;
endpackage

// [common/osc_wait_if.sv]
// Handshake between the controller and its oscillator restart timer.
`timescale 1ns/100ps
`default_nettype none
interface osc_wait_if;
  logic start;
  logic done;
  modport ctrl (output start, input done);
  modport timer (input start, output done);
endinterface
`default_nettype wire

// [src/low_power_mode_control.sv]
// Low-power mode controller: idle and stop entry, clock gating, wake-up and
// oscillator restart delay. Software and the core reach it over APB.
// Assumes the external, edge-pending, non-maskable and reset-pin inputs are asynchronous pins.
//
// How it works
// R1 - Idle opcode stacks registers, then waits
// R2 - Idle keeps oscillator, always gates CPU clock
// R3 - Idle repeats reads of stacked condition word
// R4 - Any unmasked interrupt ends idle
// R5 - Idle stops timer only if masked and watchdog off
// R6 - Converter follows its power bit only
// R7 - Serial units follow their own enables
// R8 - Stop opcode acts only if stop-disable clear
// R9 - Stop halts every clock including oscillator
// R10 - Low interrupt, reset pin, pending edge wake
// R11 - Stop freezes CPU state and pins
// R12 - Reset wake runs ordinary reset sequence
// R13 - Maskable line wakes only when unmasked
// R14 - Non-maskable line wakes regardless; services if unmasked
// R15 - Masked non-maskable wake resumes after stop
// R16 - Stabilisation delay unless wait select zero
// R17 - Delay after power-on, not warm reset
// R18 - Software clears wait select only with stable oscillator
// R19 - Skipping delay requires interrupt wake, not reset
// R20 - Reset sets masks; non-maskable mask clears once
// R21 - Stacking sets masks per interrupt kind
// R22 - Idle wake skips second push, fetches vector
// R23 - Restart delay is a parameter count
`timescale 1ns/100ps
`default_nettype none
`include "lpm_params.svh"
module low_power_mode_control #(
  parameter logic [15:0] OSC_WAIT_CYCLES = `OSC_WAIT_CYCLES // R23
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic ext_int_line_n_in,
  input wire logic ext_int_edge_pending_in,
  input wire logic nonmask_int_line_n_in,
  input wire logic reset_pin_n_in,
  input wire logic internal_int_in,
  input wire logic power_on_in,
  output logic osc_run_out,
  output logic cpu_clk_on_out,
  output logic timer_clk_on_out,
  output logic periph_clk_on_out,
  output logic converter_on_out,
  output logic sync_port_clk_out,
  output logic serial_sender_clk_out,
  output logic serial_listen_clk_out,
  output logic bus_read_out,
  output logic [15:0] bus_addr_out,
  output logic pins_frozen_out,
  output logic reset_seq_out,
  output logic vector_fetch_out,
  output logic nmi_vector_out
);
  typedef struct packed {
    lpm_pkg::lpm_state_t st;
    logic [1:0] sync_ext;
    logic [1:0] sync_edge;
    logic [1:0] sync_nmi;
    logic [1:0] sync_rst;
    logic [1:0] sync_por;
    logic [1:0] ext_s;
    logic edge_s;
    logic nmi_s;
    logic rst_s;
    logic por_s;
    logic por_prev;
    logic [5:0] ctrl;
    logic [7:0] ccw;
    logic nmi_cleared;
    logic [15:0] stack_ptr;
    logic [3:0] push_cnt;
    logic nmi_wake;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic osc_run;
    logic cpu_clk;
    logic timer_clk;
    logic periph_clk;
    logic conv_on;
    logic sync_clk;
    logic send_clk;
    logic listen_clk;
    logic bus_read;
    logic [15:0] bus_addr;
    logic frozen;
    logic reset_seq;
    logic vec_fetch;
    logic nmi_vec;
  } ctrl_state_t;
  ctrl_state_t cur, next_cur;

  osc_wait_if osc_wait ();

  osc_wait_timer #(
    .WAIT_CYCLES(OSC_WAIT_CYCLES)
  ) u_osc_wait (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .port(osc_wait)
  );

  logic wr_en;
  logic rd_en;
  logic ext_low;
  logic nmi_low;
  logic int_mask;
  logic nmi_mask;
  logic idle_wake;
  logic stop_wake;
  logic start_wait;
  logic [15:0] ccw_slot;

  always_comb begin
    wr_en = psel_in && penable_in && pwrite_in && !cur.pready;
    rd_en = psel_in && penable_in && !pwrite_in && !cur.pready;
    ext_low = !cur.ext_s[0];
    nmi_low = !cur.nmi_s;
    int_mask = cur.ccw[`CCW_INT_MASK_BIT];
    nmi_mask = cur.ccw[`CCW_NMI_MASK_BIT];
    ccw_slot = cur.stack_ptr - `CCW_STACK_DEPTH;
    idle_wake = (nmi_low && !nmi_mask) ||
                ((ext_low || cur.edge_s || internal_int_in) && !int_mask); // R4
    stop_wake = nmi_low || ((ext_low || cur.edge_s) && !int_mask); // R10 R13 R14
    start_wait = 1'b0;

    next_cur = cur;
    next_cur.sync_ext = {cur.sync_ext[0], ext_int_line_n_in};
    next_cur.sync_edge = {cur.sync_edge[0], ext_int_edge_pending_in};
    next_cur.sync_nmi = {cur.sync_nmi[0], nonmask_int_line_n_in};
    next_cur.sync_rst = {cur.sync_rst[0], reset_pin_n_in};
    next_cur.sync_por = {cur.sync_por[0], power_on_in};
    next_cur.ext_s = {cur.ext_s[0], cur.sync_ext[1]};
    next_cur.edge_s = cur.sync_edge[1];
    next_cur.nmi_s = cur.sync_nmi[1];
    next_cur.rst_s = !cur.sync_rst[1];
    // The power-on event is the rising edge of the synchronised indication.
    next_cur.por_prev = cur.sync_por[1];
    next_cur.por_s = cur.sync_por[1] && !cur.por_prev;
    next_cur.vec_fetch = 1'b0;
    next_cur.reset_seq = 1'b0;
    next_cur.pready = 1'b0;
    next_cur.pslverr = 1'b0;

    if (rd_en) begin
      next_cur.pready = 1'b1;
      unique case (paddr_in)
        `CTRL_OFFSET: next_cur.prdata = {26'h000_0000, cur.ctrl};
        `STATUS_OFFSET: next_cur.prdata = {29'h0000_0000, cur.st};
        `CCW_OFFSET: next_cur.prdata = {24'h00_0000, cur.ccw};
        `STACK_OFFSET: next_cur.prdata = {16'h0000, cur.stack_ptr};
        `OPCODE_OFFSET: next_cur.prdata = 32'h0000_0000;
        default: begin
          next_cur.prdata = 32'h0000_0000;
          next_cur.pslverr = 1'b1;
        end
      endcase
    end else if (wr_en) begin
      next_cur.pready = 1'b1;
      unique case (paddr_in)
        `CTRL_OFFSET: next_cur.ctrl = pwdata_in[5:0];
        `CCW_OFFSET: begin
          next_cur.ccw = pwdata_in[7:0];
          // Once cleared, the non-maskable mask cannot be set by software again.
          next_cur.ccw[`CCW_NMI_MASK_BIT] = pwdata_in[`CCW_NMI_MASK_BIT] &&
                                            !cur.nmi_cleared; // R20
          if (!pwdata_in[`CCW_NMI_MASK_BIT]) begin
            next_cur.nmi_cleared = 1'b1; // R20
          end
        end
        `STACK_OFFSET: next_cur.stack_ptr = pwdata_in[15:0];
        `OPCODE_OFFSET: begin
          if (cur.st == lpm_pkg::RUN) begin
            if (pwdata_in[1:0] == `CMD_IDLE) begin
              next_cur.st = lpm_pkg::STACKING; // R1
              next_cur.push_cnt = 4'h0;
            end else if (pwdata_in[1:0] == `CMD_STOP && !cur.ccw[`CCW_STOP_DIS_BIT]) begin
              next_cur.st = lpm_pkg::STOPPED; // R8
            end
          end
        end
        default: next_cur.pslverr = 1'b1;
      endcase
    end

    unique case (cur.st)
      lpm_pkg::RUN: begin
        next_cur.cpu_clk = 1'b1;
        next_cur.osc_run = 1'b1;
        next_cur.periph_clk = 1'b1;
        next_cur.timer_clk = 1'b1;
        next_cur.frozen = 1'b0;
        next_cur.bus_read = 1'b0;
      end
      lpm_pkg::STACKING: begin
        // One register byte per cycle, nine in all, down from the stack pointer.
        next_cur.bus_read = 1'b0;
        next_cur.osc_run = 1'b1;
        next_cur.frozen = 1'b0;
        next_cur.push_cnt = cur.push_cnt + 4'h1;
        if (cur.push_cnt == `CCW_STACK_DEPTH) begin
          next_cur.st = lpm_pkg::IDLE; // R1
        end
      end
      lpm_pkg::IDLE: begin
        next_cur.cpu_clk = 1'b0; // R2
        next_cur.osc_run = 1'b1; // R2
        next_cur.periph_clk = 1'b1;
        next_cur.timer_clk = !(int_mask && cur.ctrl[`CTRL_WDOG_OFF_BIT]); // R5
        next_cur.bus_read = 1'b1; // R3
        next_cur.bus_addr = ccw_slot; // R3
        if (idle_wake) begin
          next_cur.nmi_wake = nmi_low && !nmi_mask;
          next_cur.st = lpm_pkg::VECTOR; // R22
        end
      end
      lpm_pkg::STOPPED: begin
        next_cur.cpu_clk = 1'b0; // R9
        next_cur.osc_run = 1'b0; // R9
        next_cur.periph_clk = 1'b0; // R9
        next_cur.timer_clk = 1'b0; // R9
        next_cur.bus_read = 1'b0;
        next_cur.frozen = 1'b1; // R11
        next_cur.push_cnt = 4'h0;
        if (stop_wake) begin
          // Masked non-maskable wake simply resumes after the stop opcode.
          next_cur.nmi_wake = nmi_low && !nmi_mask; // R14 R15
          start_wait = cur.ctrl[`CTRL_WAIT_SEL_BIT]; // R16
          next_cur.st = start_wait ? lpm_pkg::OSC_WAIT : lpm_pkg::RUN;
          if (!start_wait && nmi_low && !nmi_mask) begin
            next_cur.st = lpm_pkg::STACKING; // R14
          end
        end
      end
      lpm_pkg::OSC_WAIT: begin
        // The core stays gated until the oscillator has settled.
        next_cur.osc_run = 1'b1;
        next_cur.cpu_clk = 1'b0; // R16
        next_cur.frozen = 1'b0;
        next_cur.push_cnt = 4'h0;
        if (osc_wait.done) begin
          next_cur.st = cur.nmi_wake ? lpm_pkg::STACKING : lpm_pkg::RUN; // R14 R15
        end
      end
      lpm_pkg::VECTOR: begin
        next_cur.vec_fetch = 1'b1; // R22
        next_cur.bus_read = 1'b0; // R3
        next_cur.nmi_vec = cur.nmi_wake;
        next_cur.ccw[`CCW_INT_MASK_BIT] = 1'b1; // R21
        if (cur.nmi_wake) begin
          next_cur.ccw[`CCW_NMI_MASK_BIT] = 1'b1; // R21
        end
        next_cur.nmi_wake = 1'b0;
        next_cur.st = lpm_pkg::RUN;
      end
      default: next_cur.st = lpm_pkg::RUN;
    endcase

    // A stacking that follows a stop wake leads to service, not to idle.
    if (cur.st == lpm_pkg::STACKING && cur.push_cnt == `CCW_STACK_DEPTH && cur.nmi_wake) begin
      next_cur.st = lpm_pkg::VECTOR; // R14
    end

    next_cur.conv_on = cur.ctrl[`CTRL_CONV_ON_BIT]; // R6
    next_cur.sync_clk = cur.ctrl[`CTRL_SYNC_ON_BIT] && cur.periph_clk; // R7
    next_cur.send_clk = cur.ctrl[`CTRL_SEND_ON_BIT] && cur.periph_clk; // R7
    next_cur.listen_clk = cur.ctrl[`CTRL_LISTEN_ON_BIT] && cur.periph_clk; // R7

    // Reset pin: ordinary reset sequence, state restored, wait select set again.
    if (cur.rst_s) begin
      next_cur.reset_seq = 1'b1; // R12
      next_cur.ctrl = `CTRL_RESET; // R12
      next_cur.ccw = `CCW_RESET; // R20
      next_cur.nmi_cleared = 1'b0;
      next_cur.nmi_wake = 1'b0;
      next_cur.frozen = 1'b0;
      // Warm reset with clocks running needs no delay; from stop the delay is kept,
      // and a pin held low restarts it, so the count runs from the release.
      start_wait = (cur.st == lpm_pkg::STOPPED) || (cur.st == lpm_pkg::OSC_WAIT); // R17
      next_cur.st = start_wait ? lpm_pkg::OSC_WAIT : lpm_pkg::RUN; // R10
    end
    if (cur.por_s) begin
      start_wait = 1'b1; // R17
      next_cur.st = lpm_pkg::OSC_WAIT;
      next_cur.reset_seq = 1'b1;
    end
  end

  assign osc_wait.start = start_wait;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cur <= '0;
      cur.st <= lpm_pkg::RUN;
      cur.sync_ext <= 2'h3;
      cur.sync_nmi <= 2'h3;
      cur.sync_rst <= 2'h3;
      cur.ext_s <= 2'h3;
      cur.nmi_s <= 1'b1;
      cur.ctrl <= `CTRL_RESET; // R16
      cur.ccw <= `CCW_RESET; // R20
      cur.stack_ptr <= `STACK_TOP;
      cur.osc_run <= 1'b1;
      cur.cpu_clk <= 1'b1;
      cur.timer_clk <= 1'b1;
      cur.periph_clk <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  assign prdata_out = cur.prdata;
  assign pready_out = cur.pready;
  assign pslverr_out = cur.pslverr;
  assign osc_run_out = cur.osc_run;
  assign cpu_clk_on_out = cur.cpu_clk;
  assign timer_clk_on_out = cur.timer_clk;
  assign periph_clk_on_out = cur.periph_clk;
  assign converter_on_out = cur.conv_on;
  assign sync_port_clk_out = cur.sync_clk;
  assign serial_sender_clk_out = cur.send_clk;
  assign serial_listen_clk_out = cur.listen_clk;
  assign bus_read_out = cur.bus_read;
  assign bus_addr_out = cur.bus_addr;
  assign pins_frozen_out = cur.frozen;
  assign reset_seq_out = cur.reset_seq;
  assign vector_fetch_out = cur.vec_fetch;
  assign nmi_vector_out = cur.nmi_vec;
endmodule // low_power_mode_control
`default_nettype wire

// [src/osc_wait_timer.sv]
// Oscillator stabilisation counter. Started by a one-cycle pulse, it answers
// with a one-cycle done pulse after the configured count of clock cycles.
`timescale 1ns/100ps
`default_nettype none
`include "lpm_params.svh"
module osc_wait_timer #(
  parameter logic [15:0] WAIT_CYCLES = `OSC_WAIT_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_in,
  osc_wait_if.timer port
);
  typedef struct packed {
    logic busy;
    logic [15:0] count;
    logic done;
  } timer_state_t;
  timer_state_t cur, next_cur;

  always_comb begin
    next_cur = cur;
    next_cur.done = 1'b0;
    if (port.start) begin
      next_cur.busy = 1'b1;
      next_cur.count = WAIT_CYCLES;
    end else if (cur.busy) begin
      if (cur.count <= 16'h0001) begin
        next_cur.busy = 1'b0;
        next_cur.done = 1'b1;
      end else begin
        next_cur.count = cur.count - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign port.done = cur.done;
endmodule // osc_wait_timer
`default_nettype wire

// [testbench/low_power_mode_control_tb.sv]
// Self-checking bench for the low-power mode controller over APB.
// Assumes the restart delay is shortened to 8 cycles by parameter.
`timescale 1ns/100ps
`default_nettype none
module low_power_mode_control_tb;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0000_0000;
  logic power_on_in = 1'b0;
  logic [31:0] prdata_out;
  logic [15:0] bus_addr_out;
  logic pready_out, pslverr_out, ext_int_line_n_in, ext_int_edge_pending_in;
  logic nonmask_int_line_n_in, reset_pin_n_in, internal_int_in, osc_run_out;
  logic cpu_clk_on_out, timer_clk_on_out, periph_clk_on_out, converter_on_out;
  logic sync_port_clk_out, serial_sender_clk_out, serial_listen_clk_out;
  logic bus_read_out, pins_frozen_out, reset_seq_out, vector_fetch_out, nmi_vector_out;
  logic [31:0] rd;
  logic er;
  int fail_count = 0;
  int checks = 0;
  always #20 clk_in = !clk_in;
  low_power_mode_control #(.OSC_WAIT_CYCLES(16'h0008)) DUT (.clk_in, .rst_in, .psel_in,
    .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
    .ext_int_line_n_in, .ext_int_edge_pending_in, .nonmask_int_line_n_in, .reset_pin_n_in,
    .internal_int_in, .power_on_in, .osc_run_out, .cpu_clk_on_out, .timer_clk_on_out,
    .periph_clk_on_out, .converter_on_out, .sync_port_clk_out, .serial_sender_clk_out,
    .serial_listen_clk_out, .bus_read_out, .bus_addr_out, .pins_frozen_out, .reset_seq_out,
    .vector_fetch_out, .nmi_vector_out);
  lpm_far_side far (.clk_in, .ext_int_line_n_out(ext_int_line_n_in),
    .edge_pending_out(ext_int_edge_pending_in), .nmi_line_n_out(nonmask_int_line_n_in),
    .reset_pin_n_out(reset_pin_n_in), .internal_int_out(internal_int_in));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    // Ready and read data are taken as they stand at the rising edge.
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 40);
    rd = prdata_out;
    er = pslverr_out;
    if (n >= 40) chk(32'h0000_0000, 32'h0000_0001);
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd & m, e);
  endtask
  function automatic logic sig(input int k);
    case (k)
      0: sig = bus_read_out;
      1: sig = pins_frozen_out;
      2: sig = cpu_clk_on_out;
      default: sig = vector_fetch_out;
    endcase
  endfunction
  task automatic till(input int k);
    int n;
    n = 0;
    while (sig(k) !== 1'b1 && n < 300) begin
      @(negedge clk_in);
      n++;
    end
    if (n >= 300) chk(32'h0000_0000, 32'h0000_0001);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #400us;
    fail_count++;
    summarize();
  end
  initial begin
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    rchk(12'h000, 32'h0000_003F, 32'h0000_0001);
    rchk(12'h008, 32'h0000_00D0, 32'h0000_00D0);
    apb(1'b0, 12'h020, 32'h0000_0000);
    chk(er, 32'h0000_0001);
    apb(1'b1, 12'h00C, 32'h0000_0002);
    rchk(12'h004, 32'h0000_0007, 32'h0000_0000);
    apb(1'b1, 12'h008, 32'h0000_0050);
    apb(1'b1, 12'h00C, 32'h0000_0002);
    till(1);
    chk({osc_run_out, cpu_clk_on_out, periph_clk_on_out, timer_clk_on_out}, 32'h0000_0000);
    far.drive(1, 1'b1);
    till(2);
    far.drive(1, 1'b0);
    rchk(12'h004, 32'h0000_0007, 32'h0000_0000);
    chk(nmi_vector_out, 32'h0000_0000);
    apb(1'b1, 12'h008, 32'h0000_0040);
    // Wait select stays set: the model stands for an internal oscillator.
    apb(1'b1, 12'h000, 32'h0000_002B);
    apb(1'b1, 12'h00C, 32'h0000_0001);
    till(0);
    rchk(12'h004, 32'h0000_0007, 32'h0000_0002);
    chk({cpu_clk_on_out, osc_run_out, timer_clk_on_out, converter_on_out, sync_port_clk_out,
      serial_sender_clk_out, serial_listen_clk_out}, 32'h0000_0035);
    chk(bus_addr_out, 32'h0000_00F7);
    far.drive(0, 1'b1);
    till(3);
    far.drive(0, 1'b0);
    rchk(12'h008, 32'h0000_0010, 32'h0000_0010);
    apb(1'b1, 12'h008, 32'h0000_0000);
    apb(1'b1, 12'h008, 32'h0000_0040);
    rchk(12'h008, 32'h0000_0040, 32'h0000_0000);
    apb(1'b1, 12'h00C, 32'h0000_0002);
    till(1);
    far.drive(1, 1'b1);
    till(3);
    far.drive(1, 1'b0);
    chk(nmi_vector_out, 32'h0000_0001);
    rchk(12'h008, 32'h0000_0050, 32'h0000_0050);
    apb(1'b1, 12'h00C, 32'h0000_0002);
    till(1);
    far.drive(2, 1'b1);
    repeat (4) @(posedge clk_in);
    far.drive(2, 1'b0);
    till(2);
    rchk(12'h000, 32'h0000_003F, 32'h0000_0001);
    rchk(12'h008, 32'h0000_00D0, 32'h0000_00D0);
    far.drive(2, 1'b1);
    repeat (4) @(posedge clk_in);
    far.drive(2, 1'b0);
    repeat (4) @(posedge clk_in);
    rchk(12'h004, 32'h0000_0007, 32'h0000_0000);
    power_on_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    power_on_in <= 1'b0;
    rchk(12'h004, 32'h0000_0007, 32'h0000_0004);
    till(2);
    apb(1'b1, 12'h008, 32'h0000_0050);
    apb(1'b1, 12'h00C, 32'h0000_0002);
    till(1);
    far.drive(3, 1'b1);
    repeat (20) @(posedge clk_in);
    chk(pins_frozen_out, 32'h0000_0001);
    far.drive(3, 1'b0);
    apb(1'b1, 12'h008, 32'h0000_0040);
    far.drive(4, 1'b1);
    till(2);
    far.drive(4, 1'b0);
    rchk(12'h004, 32'h0000_0007, 32'h0000_0000);
    apb(1'b1, 12'h00C, 32'h0000_0002);
    till(1);
    far.drive(3, 1'b1);
    till(2);
    far.drive(3, 1'b0);
    rchk(12'h004, 32'h0000_0007, 32'h0000_0000);
    summarize();
  end
endmodule // low_power_mode_control_tb
`default_nettype wire

// [testbench/lpm_far_side.sv]
// Far-side model: interrupt requests of the core and the reset pin.
// Assumes the bench asks for a level change; active-low lines are pulled high when idle.
`timescale 1ns/100ps
`default_nettype none
module lpm_far_side (
  input wire logic clk_in,
  output logic ext_int_line_n_out,
  output logic edge_pending_out,
  output logic nmi_line_n_out,
  output logic reset_pin_n_out,
  output logic internal_int_out
);
  initial begin
    ext_int_line_n_out = 1'b1;
    edge_pending_out = 1'b0;
    nmi_line_n_out = 1'b1;
    reset_pin_n_out = 1'b1;
    internal_int_out = 1'b0;
  end
  // Changes land just after an edge so the controller never sees a race.
  task automatic drive(input int k, input logic v);
    @(posedge clk_in);
    case (k)
      0: internal_int_out <= v;
      1: nmi_line_n_out <= !v;
      2: reset_pin_n_out <= !v;
      4: edge_pending_out <= v;
      default: ext_int_line_n_out <= !v;
    endcase
  endtask
endmodule // lpm_far_side
`default_nettype wire

// [testbench/lpm_monitor.sv]
// Checker for the low-power mode controller, bound to its top module.
// Assumes one clock domain and an APB master that keeps to the bus rules.
`timescale 1ns/100ps
`default_nettype none
module lpm_monitor #(
  parameter logic [15:0] OSC_WAIT_CYCLES = 16'h0008
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic nonmask_int_line_n_in,
  input wire logic reset_pin_n_in,
  input wire logic osc_run_out,
  input wire logic cpu_clk_on_out,
  input wire logic timer_clk_on_out,
  input wire logic periph_clk_on_out,
  input wire logic converter_on_out,
  input wire logic sync_port_clk_out,
  input wire logic bus_read_out,
  input wire logic pins_frozen_out,
  input wire logic reset_seq_out,
  input wire logic vector_fetch_out
);
  logic [5:0] ctrl_copy;
  logic take;
  assign take = psel_in && penable_in && pwrite_in && pready_out;
  // A reset sequence from the pin reloads control too, so the copy follows it.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_copy <= 6'h01;
    end else if (reset_seq_out) begin
      ctrl_copy <= 6'h01;
    end else if (take && paddr_in == 12'h000) begin
      ctrl_copy <= pwdata_in[5:0];
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  AST_APB_ANSWER: assert property (psel_in && penable_in && !pready_out |=> pready_out ##1 !pready_out)
    else $error("access not answered in one cycle");
  AST_ERR_WITH_READY: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  AST_IDLE_ENTRY: assert property (take && paddr_in == 12'h00C && pwdata_in[1:0] == 2'h1 && cpu_clk_on_out |-> ##[4:14] bus_read_out)
    else $error("idle not entered after stacking");
  AST_IDLE_CLOCKS: assert property (bus_read_out |-> osc_run_out && !cpu_clk_on_out)
    else $error("idle clocks wrong");
  AST_IDLE_UNITS: assert property (bus_read_out |-> converter_on_out == ctrl_copy[2] && sync_port_clk_out == ctrl_copy[3])
    else $error("unit does not follow its enable in idle");
  AST_STOP_CLOCKS: assert property (pins_frozen_out |-> !osc_run_out && !cpu_clk_on_out && !timer_clk_on_out && !periph_clk_on_out)
    else $error("clock running in stop");
  AST_NMI_WAKE: assert property (pins_frozen_out && !nonmask_int_line_n_in |-> ##[1:8] !pins_frozen_out)
    else $error("low non-maskable line did not end stop");
  AST_RESET_WAKE: assert property ($fell(reset_pin_n_in) |-> ##[1:8] reset_seq_out)
    else $error("reset pin gave no reset sequence");
  AST_OSC_DELAY: assert property ($rose(osc_run_out) && ctrl_copy[0] |-> !cpu_clk_on_out [*4])
    else $error("core clock before oscillator settled");
  AST_IDLE_VECTOR: assert property ($fell(bus_read_out) |-> ##[0:3] vector_fetch_out)
    else $error("idle wake without vector fetch");
endmodule // lpm_monitor
bind low_power_mode_control lpm_monitor #(.OSC_WAIT_CYCLES(OSC_WAIT_CYCLES)) mon (.clk_in, .rst_in,
  .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pready_out, .pslverr_out,
  .nonmask_int_line_n_in, .reset_pin_n_in, .osc_run_out, .cpu_clk_on_out, .timer_clk_on_out,
  .periph_clk_on_out, .converter_on_out, .sync_port_clk_out, .bus_read_out, .pins_frozen_out,
  .reset_seq_out, .vector_fetch_out);
`default_nettype wire
